// [design/rmp_pkg.sv]
// Purpose: shared constants and types for the output remap register block
// Assumes: 32-bit AHB-Lite slave, one aligned word per register
// Notes:   field layout of the 16-bit select register
`default_nettype none
package rmp_pkg;
    // ==========================================================
    // register map
    localparam logic [11:0] RMP_OFS_SELECT = 12'h000;  // output select for pins 30 and 31
    localparam logic [11:0] RMP_OFS_STATUS = 12'h004;  // block state readback
    localparam logic [15:0] RMP_SELECT_RST = 16'h0000;
    // ==========================================================
    // field layout
    localparam int RMP_PIN31_LSB = 8;
    localparam int RMP_PIN30_LSB = 0;
    localparam int RMP_SEL_W     = 6;
    localparam logic [15:0] RMP_SELECT_MASK = 16'h3f3f; // bits 13-8 and 5-0 implemented
    localparam int RMP_NUM_PERIPH = 64;
    localparam logic [5:0] RMP_SEL_NONE = 6'h00;

    // ==========================================================
    // ahb request carried to the register file
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
    } rmp_req_t;

    // ==========================================================
    // one-pin route result
    typedef struct packed {
        logic value;
        logic enable;
        logic active;
    } rmp_route_t;

    // pick one select field from the register image
    function automatic logic [5:0] rmp_field(input logic [15:0] image, input int lsb);
        rmp_field = image[lsb +: RMP_SEL_W];
    endfunction
endpackage
`default_nettype wire

// [design/rmp_pin_route.sv]
// Purpose: route one peripheral output onto one remappable pin
// Assumes: select zero means port control owns the pin
// Notes:   purely combinational; the top registers its outputs
`default_nettype none
module rmp_pin_route
    import rmp_pkg::*;
(
    input  wire logic [5:0]                select_i,
    input  wire logic [RMP_NUM_PERIPH-1:0] periph_out_i,
    input  wire logic [RMP_NUM_PERIPH-1:0] periph_oe_i,
    input  wire logic                      port_out_i,
    input  wire logic                      port_oe_i,
    output rmp_route_t                     route_o
);
    // ==========================================================
    // mux selection
    always_comb begin
        if (select_i == RMP_SEL_NONE) begin
            route_o = '{value: port_out_i, enable: port_oe_i, active: 1'b0};
        end else begin
            route_o = '{value: periph_out_i[select_i], enable: periph_oe_i[select_i], active: 1'b1};
        end
    end
endmodule
`default_nettype wire

// [design/rmp_ahb_slave.sv]
// Purpose: AHB-Lite slave front end, zero wait states, always OKAY
// Assumes: single word transfers only
// Notes:   latches the address phase and presents it in the data phase
`default_nettype none
module rmp_ahb_slave
    import rmp_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic        hready_i,
    output rmp_req_t         req_o
);
    rmp_req_t req_reg;
    rmp_req_t req_next;

    // ==========================================================
    // capture address phase when a transfer is taken
    always_comb begin
        req_next = '0;
        if (hready_i && hsel_i && htrans_i[1]) begin
            req_next.wr   = hwrite_i;
            req_next.rd   = !hwrite_i;
            req_next.addr = haddr_i[11:0];
        end else if (!hready_i) begin
            req_next = req_reg;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            req_reg <= '0;
        end else begin
            req_reg <= req_next;
        end
    end

    assign req_o = req_reg;
endmodule
`default_nettype wire

// [design/rmp_remap_top.sv]
// Purpose: output remap select register for remappable pins 30 and 31
// Assumes: AHB-Lite register access, 250 MHz clock, synchronous reset
// Notes:   small package variant strapped by a static input
// Behaviour
// - bits 13-8 pick the peripheral output driving remappable pin 31
// - bits 5-0 pick the peripheral output driving remappable pin 30
// - bits 15-14 read zero and ignore writes
// - bits 7-6 read zero and ignore writes
// - on the small package the register reads zero and writes do nothing
//
// Design decisions made here: the register offsets and the AHB-Lite register port.
`default_nettype none
module rmp_remap_top
    import rmp_pkg::*;
(
    input  wire logic                      clock_i,
    input  wire logic                      reset_i,
    input  wire logic                      small_package_i,
    input  wire logic                      hsel_i,
    input  wire logic [31:0]               haddr_i,
    input  wire logic [1:0]                htrans_i,
    input  wire logic                      hwrite_i,
    input  wire logic [2:0]                hsize_i,
    input  wire logic [31:0]               hwdata_i,
    input  wire logic                      hready_i,
    output logic [31:0]                    hrdata_o,
    output logic                           hreadyout_o,
    output logic                           hresp_o,
    input  wire logic [RMP_NUM_PERIPH-1:0] periph_out_i,
    input  wire logic [RMP_NUM_PERIPH-1:0] periph_oe_i,
    input  wire logic [1:0]                port_out_i,
    input  wire logic [1:0]                port_oe_i,
    output logic                           remappable_pin_30_o,
    output logic                           remappable_pin_30_oe_o,
    output logic                           remappable_pin_31_o,
    output logic                           remappable_pin_31_oe_o
);
    rmp_req_t    req;
    rmp_route_t  route30;
    rmp_route_t  route31;
    logic [15:0] select_reg;
    logic [15:0] select_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        small_reg;
    logic        small_next;
    logic        small_meta_reg;
    logic [3:0]  pins_reg;
    logic [3:0]  pins_next;
    logic [5:0]  pin30_output_select;
    logic [5:0]  pin31_output_select;

    // ==========================================================
    // bus front end
    rmp_ahb_slave u_slave (
        .clock_i  (clock_i),
        .reset_i  (reset_i),
        .hsel_i   (hsel_i),
        .haddr_i  (haddr_i),
        .htrans_i (htrans_i),
        .hwrite_i (hwrite_i),
        .hready_i (hready_i),
        .req_o    (req)
    );

    // package strap comes from a pin: two flip-flops before any logic reads it
    always_comb begin
        small_next = small_meta_reg;
    end

    // ==========================================================
    // select register write path
    always_comb begin
        select_next = select_reg;
        if (req.wr && req.addr == RMP_OFS_SELECT && !small_reg) begin
            select_next = hwdata_i[15:0] & RMP_SELECT_MASK;
        end
        if (small_reg) begin
            select_next = RMP_SELECT_RST;
        end
    end

    assign pin31_output_select = rmp_field(select_reg, RMP_PIN31_LSB);
    assign pin30_output_select = rmp_field(select_reg, RMP_PIN30_LSB);

    // read data for the next data phase
    always_comb begin
        rdata_next = '0;
        if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
            unique case (haddr_i[11:0])
                RMP_OFS_SELECT: rdata_next = {16'h0000, select_next & RMP_SELECT_MASK};
                RMP_OFS_STATUS: rdata_next = {28'h0000000, route31.active, route30.active,
                                              small_reg, 1'b0};
                default:        rdata_next = '0;
            endcase
        end
    end

    // ==========================================================
    // pin routing
    rmp_pin_route u_pin30 (
        .select_i     (pin30_output_select),
        .periph_out_i (periph_out_i),
        .periph_oe_i  (periph_oe_i),
        .port_out_i   (port_out_i[0]),
        .port_oe_i    (port_oe_i[0]),
        .route_o      (route30)
    );

    rmp_pin_route u_pin31 (
        .select_i     (pin31_output_select),
        .periph_out_i (periph_out_i),
        .periph_oe_i  (periph_oe_i),
        .port_out_i   (port_out_i[1]),
        .port_oe_i    (port_oe_i[1]),
        .route_o      (route31)
    );

    // registered pin drive; select zero falls back to port control
    always_comb begin
        pins_next = {route31.enable, route31.value, route30.enable, route30.value};
    end

    // ==========================================================
    // state registers
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            select_reg <= RMP_SELECT_RST;
            rdata_reg  <= '0;
            pins_reg   <= '0;
            small_reg  <= 1'b0;
            small_meta_reg <= 1'b0;
        end else begin
            select_reg <= select_next;
            rdata_reg  <= rdata_next;
            pins_reg   <= pins_next;
            small_reg  <= small_next;
            small_meta_reg <= small_package_i;   // first stage, read only by small_next
        end
    end

    assign hrdata_o               = rdata_reg;
    assign hreadyout_o            = 1'b1;    // zero wait states
    assign hresp_o                = 1'b0;    // always OKAY
    assign remappable_pin_30_o    = pins_reg[0];
    assign remappable_pin_30_oe_o = pins_reg[1];
    assign remappable_pin_31_o    = pins_reg[2];
    assign remappable_pin_31_oe_o = pins_reg[3];

    // ==========================================================
    // checks
    // write data phase landing on the select register
    sequence s_sel_write;
        req.wr && req.addr == RMP_OFS_SELECT;
    endsequence

    // read of the select register taken in its address phase
    sequence s_sel_read;
        hready_i && hsel_i && htrans_i[1] && !hwrite_i && haddr_i[11:0] == RMP_OFS_SELECT;
    endsequence

    // read of the status word taken in its address phase
    sequence s_status_read;
        hready_i && hsel_i && htrans_i[1] && !hwrite_i && haddr_i[11:0] == RMP_OFS_STATUS;
    endsequence

    // read of an offset with no register behind it
    sequence s_other_read;
        hready_i && hsel_i && htrans_i[1] && !hwrite_i &&
        haddr_i[11:0] != RMP_OFS_SELECT && haddr_i[11:0] != RMP_OFS_STATUS;
    endsequence

    // cycle in which no write lands on the select register
    sequence s_sel_quiet;
        !(req.wr && req.addr == RMP_OFS_SELECT);
    endsequence

    // small package strap seen on two cycles in a row
    sequence s_small_held;
        small_reg ##1 small_reg;
    endsequence

    // ==========================================================
    // select fields load from the write data and hold otherwise
    AST_PIN31_FIELD: assert property (@(posedge clock_i) disable iff (reset_i)
        (s_sel_write and !small_reg) |=> pin31_output_select == $past(hwdata_i[13:8]))
        else $error("pin31 select not loaded");

    AST_PIN30_FIELD: assert property (@(posedge clock_i) disable iff (reset_i)
        (s_sel_write and !small_reg) |=> pin30_output_select == $past(hwdata_i[5:0]))
        else $error("pin30 select not loaded");

    AST_SEL_HOLD: assert property (@(posedge clock_i) disable iff (reset_i)
        (s_sel_quiet and !small_reg) |=> select_reg == $past(select_reg))
        else $error("select register changed without a write");

    // ==========================================================
    // unimplemented bits stay zero in storage and on readback
    AST_HIGH_ZERO: assert property (@(posedge clock_i) disable iff (reset_i)
        select_reg[15:14] == 2'b00 && hrdata_o[15:14] == 2'b00)
        else $error("bits 15-14 not zero");

    AST_MID_ZERO: assert property (@(posedge clock_i) disable iff (reset_i)
        select_reg[7:6] == 2'b00 && hrdata_o[7:6] == 2'b00)
        else $error("bits 7-6 not zero");

    AST_SEL_UPPER_READ: assert property (@(posedge clock_i) disable iff (reset_i)
        s_sel_read |=> hrdata_o[31:14] == 18'h00000 && hrdata_o[7:6] == 2'b00)
        else $error("select readback has unimplemented bits set");

    // ==========================================================
    // a nonzero select routes that peripheral output onto the pin
    AST_PERIPH_31: assert property (@(posedge clock_i) disable iff (reset_i)
        pin31_output_select != 6'h00 |=> remappable_pin_31_oe_o == $past(periph_oe_i[pin31_output_select]))
        else $error("pin31 enable not from peripheral");

    AST_PERIPH_31_VAL: assert property (@(posedge clock_i) disable iff (reset_i)
        pin31_output_select != 6'h00 |=> remappable_pin_31_o == $past(periph_out_i[pin31_output_select]))
        else $error("pin31 value not from peripheral");

    AST_PERIPH_30_OE: assert property (@(posedge clock_i) disable iff (reset_i)
        pin30_output_select != 6'h00 |=> remappable_pin_30_oe_o == $past(periph_oe_i[pin30_output_select]))
        else $error("pin30 enable not from peripheral");

    AST_PERIPH_30_VAL: assert property (@(posedge clock_i) disable iff (reset_i)
        pin30_output_select != 6'h00 |=> remappable_pin_30_o == $past(periph_out_i[pin30_output_select]))
        else $error("pin30 value not from peripheral");

    // ==========================================================
    // select zero hands the pin back to the ordinary port
    AST_PORT_CTRL: assert property (@(posedge clock_i) disable iff (reset_i)
        pin30_output_select == 6'h00 |=> remappable_pin_30_o == $past(port_out_i[0]))
        else $error("pin30 not under port control");

    AST_PORT_CTRL_30_OE: assert property (@(posedge clock_i) disable iff (reset_i)
        pin30_output_select == 6'h00 |=> remappable_pin_30_oe_o == $past(port_oe_i[0]))
        else $error("pin30 enable not under port control");

    AST_PORT_CTRL_31: assert property (@(posedge clock_i) disable iff (reset_i)
        pin31_output_select == 6'h00 |=> remappable_pin_31_o == $past(port_out_i[1]))
        else $error("pin31 not under port control");

    AST_PORT_CTRL_31_OE: assert property (@(posedge clock_i) disable iff (reset_i)
        pin31_output_select == 6'h00 |=> remappable_pin_31_oe_o == $past(port_oe_i[1]))
        else $error("pin31 enable not under port control");

    // ==========================================================
    // small package: register absent, writes dropped, pin values on port control
    AST_SMALL_PKG: assert property (@(posedge clock_i) disable iff (reset_i)
        small_reg |=> select_reg == 16'h0000)
        else $error("small package register not zero");

    AST_SMALL_WRITE: assert property (@(posedge clock_i) disable iff (reset_i)
        (s_sel_write and small_reg) |=> select_reg == 16'h0000)
        else $error("small package write took effect");

    AST_SMALL_READ: assert property (@(posedge clock_i) disable iff (reset_i)
        (s_sel_read and small_reg) |=> hrdata_o == 32'h00000000)
        else $error("small package read not zero");

    AST_SMALL_PINS_30: assert property (@(posedge clock_i) disable iff (reset_i)
        s_small_held |=> remappable_pin_30_o == $past(port_out_i[0]))
        else $error("small package pin30 not under port control");

    AST_SMALL_PINS_31: assert property (@(posedge clock_i) disable iff (reset_i)
        s_small_held |=> remappable_pin_31_o == $past(port_out_i[1]))
        else $error("small package pin31 not under port control");

    // ==========================================================
    // read data in the data phase after each read is taken
    AST_READBACK: assert property (@(posedge clock_i) disable iff (reset_i)
        s_sel_read |=> hrdata_o[15:0] == (small_reg ? 16'h0000 : select_reg))
        else $error("readback mismatch");

    AST_STATUS_ACT31: assert property (@(posedge clock_i) disable iff (reset_i)
        s_status_read |=> hrdata_o[3] == ($past(pin31_output_select) != 6'h00))
        else $error("status pin31 active bit wrong");

    AST_STATUS_ACT30: assert property (@(posedge clock_i) disable iff (reset_i)
        s_status_read |=> hrdata_o[2] == ($past(pin30_output_select) != 6'h00))
        else $error("status pin30 active bit wrong");

    AST_STATUS_SMALL: assert property (@(posedge clock_i) disable iff (reset_i)
        s_status_read |=> hrdata_o[1] == $past(small_reg))
        else $error("status small package bit wrong");

    AST_STATUS_HIGH: assert property (@(posedge clock_i) disable iff (reset_i)
        s_status_read |=> hrdata_o[31:4] == 28'h0000000 && hrdata_o[0] == 1'b0)
        else $error("status unused bits not zero");

    AST_UNMAPPED_READ: assert property (@(posedge clock_i) disable iff (reset_i)
        s_other_read |=> hrdata_o == 32'h00000000)
        else $error("unmapped read not zero");

    // ==========================================================
    // bus response and reset state
    AST_BUS_OKAY: assert property (@(posedge clock_i) disable iff (reset_i)
        hresp_o == 1'b0 && hreadyout_o == 1'b1)
        else $error("bus response not ready and okay");

    AST_RESET_STATE: assert property (@(posedge clock_i)
        reset_i |=> select_reg == RMP_SELECT_RST && pins_reg == 4'h0 && hrdata_o == 32'h00000000)
        else $error("reset state not clear");
endmodule
`default_nettype wire

// [tb/tb_rmp_remap_top.sv]
// Purpose: self-checking bench for the output remap select register block
// Assumes: zero wait state AHB-Lite slave, select register at RMP_OFS_SELECT
// Notes:   reset value first, then table rows, status, unmapped, reset and small package cases
`default_nettype none
module tb_rmp_remap_top
    import rmp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // signals
    logic                      clock_i = 1'b0;
    logic                      reset_i = 1'b1;
    logic                      small_package_i = 1'b0;
    logic                      hsel_i = 1'b0;
    logic [31:0]               haddr_i = 32'h0;
    logic [1:0]                htrans_i = 2'h0;
    logic                      hwrite_i = 1'b0;
    logic [31:0]               hwdata_i = 32'h0;
    logic [31:0]               hrdata_o;
    logic                      hreadyout_o;
    logic                      hresp_o;
    logic [RMP_NUM_PERIPH-1:0] periph_out_i = 64'hf0e1d2c3b4a59687;
    logic [RMP_NUM_PERIPH-1:0] periph_oe_i = 64'h5a3c96a5c3691e87;
    logic [1:0]                port_out_i = 2'h2;
    logic [1:0]                port_oe_i = 2'h1;
    logic                      remappable_pin_30_o;
    logic                      remappable_pin_30_oe_o;
    logic                      remappable_pin_31_o;
    logic                      remappable_pin_31_oe_o;
    int                        num_errors = 0;
    int                        n_checks = 0;
    logic [31:0]               rd;
    logic [31:0]               wr_tab [6] = '{32'hffffffff, 32'h0000c0c0, 32'h00002a15,
                                              32'h00000100, 32'hdead0001, 32'h0000ff00};
    logic [15:0]               ex_tab [6] = '{16'h3f3f, 16'h0000, 16'h2a15, 16'h0100, 16'h0001, 16'h3f00};
    // ==========================================================
    // clock and device
    always #2 clock_i = ~clock_i;
    rmp_remap_top i_dut (
        .clock_i(clock_i), .reset_i(reset_i), .small_package_i(small_package_i),
        .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .periph_out_i(periph_out_i),
        .periph_oe_i(periph_oe_i), .port_out_i(port_out_i), .port_oe_i(port_oe_i),
        .remappable_pin_30_o(remappable_pin_30_o), .remappable_pin_30_oe_o(remappable_pin_30_oe_o),
        .remappable_pin_31_o(remappable_pin_31_o), .remappable_pin_31_oe_o(remappable_pin_31_oe_o)
    );
    // ==========================================================
    // compare, verdict and bus tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // one single word transfer; ready and read data sampled on the falling edge
    task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        logic rdy;
        @(posedge clock_i);
        hsel_i <= 1'b1;
        haddr_i <= a;
        htrans_i <= 2'h2;
        hwrite_i <= wr;
        do begin
            @(negedge clock_i);
            rdy = hreadyout_o;
            @(posedge clock_i);
        end while (rdy !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do begin
            @(negedge clock_i);
            rdy = hreadyout_o;
            q = hrdata_o;
            check({31'h0, hresp_o}, 32'h0);
            @(posedge clock_i);
        end while (rdy !== 1'b1);
    endtask
    // expected pin pair {oe, value} for a select field
    function automatic logic [31:0] exp_pin(input logic [5:0] s, input int p);
        if (s == RMP_SEL_NONE)
            return {30'h0, port_oe_i[p], port_out_i[p]};
        return {30'h0, periph_oe_i[s], periph_out_i[s]};
    endfunction
    // let the select land, then compare both pins
    task automatic chk_pins(input logic [15:0] img);
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
        check({30'h0, remappable_pin_30_oe_o, remappable_pin_30_o}, exp_pin(img[5:0], 0));
        check({30'h0, remappable_pin_31_oe_o, remappable_pin_31_o}, exp_pin(img[13:8], 1));
    endtask
    // ==========================================================
    // watchdog
    initial begin
        repeat (5000) @(posedge clock_i);
        num_errors++;
        finish_test();
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (8) @(posedge clock_i);
        reset_i <= 1'b0;
        ahb_xfer(1'b0, {20'h0, RMP_OFS_SELECT}, 32'h0, rd);
        check(rd, {16'h0, RMP_SELECT_RST});
        chk_pins(16'h0000);
        // table rows: write, pins, read back
        for (int i = 0; i < 6; i++) begin
            ahb_xfer(1'b1, {20'h0, RMP_OFS_SELECT}, wr_tab[i], rd);
            chk_pins(ex_tab[i]);
            ahb_xfer(1'b0, {20'h0, RMP_OFS_SELECT}, 32'h0, rd);
            check(rd, {16'h0, ex_tab[i]});
        end
        // pin 31 remapped and pin 30 on port control shows in the status word
        ahb_xfer(1'b0, {20'h0, RMP_OFS_STATUS}, 32'h0, rd);
        check(rd, 32'h00000008);
        // unmapped write leaves select alone and reads zero
        ahb_xfer(1'b1, 32'h0000000c, 32'h00001111, rd);
        ahb_xfer(1'b0, 32'h0000000c, 32'h0, rd);
        check(rd, 32'h0);
        ahb_xfer(1'b0, {20'h0, RMP_OFS_SELECT}, 32'h0, rd);
        check(rd, 32'h00003f00);
        // reset in mid-run returns the pins to port control
        @(posedge clock_i);
        reset_i <= 1'b1;
        port_out_i <= 2'h1;
        port_oe_i <= 2'h2;
        repeat (2) @(posedge clock_i);
        reset_i <= 1'b0;
        chk_pins(16'h0000);
        ahb_xfer(1'b0, {20'h0, RMP_OFS_SELECT}, 32'h0, rd);
        check(rd, 32'h0);
        // small package: a loaded register is cleared, reads zero, writes do nothing
        ahb_xfer(1'b1, {20'h0, RMP_OFS_SELECT}, 32'h00003f3f, rd);
        chk_pins(16'h3f3f);
        @(posedge clock_i);
        small_package_i <= 1'b1;
        periph_out_i <= ~periph_out_i;
        repeat (3) @(posedge clock_i);
        ahb_xfer(1'b1, {20'h0, RMP_OFS_SELECT}, 32'h00002a15, rd);
        chk_pins(16'h0000);
        ahb_xfer(1'b0, {20'h0, RMP_OFS_SELECT}, 32'h0, rd);
        check(rd, 32'h0);
        ahb_xfer(1'b0, {20'h0, RMP_OFS_STATUS}, 32'h0, rd);
        check(rd, 32'h00000002);
        finish_test();
    end
endmodule
`default_nettype wire
